// ==== logic/ldfm_top.sv ====
// Purpose: fault latching and open-drain interrupt for a flash/torch driver
// Assumes: rst covers enable low, undervoltage lockout and power-on reset
// Notes:   analog current paths are outside this block
`include "ldfm_cfg.svh"
module ldfm_top (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             interface_select,
  input  wire logic             mode_select_hi,
  input  wire logic             mode_select_lo,
  input  wire logic             flash_trigger_in,
  input  wire logic             timed_flash_select,
  input  wire logic [3:0]       flash_duration_code,
  input  wire logic             torch_enable,
  input  wire logic             out_sel_wr,
  input  wire logic [7:0]       out_sel_data,
  input  wire logic             overvoltage_cmp,
  input  wire logic             overtemp_cmp,
  input  wire logic             high_power_led_cathode,
  output logic                  int_n_o,
  output logic                  int_n_oe_n,
  output ldfm_pkg::ldfm_flags_t fault_flags,
  output logic                  driver_enable
);
  import ldfm_pkg::*;

  ldfm_sync_if sif ();
  // cathode is sampled as "grounded" level, so invert before syncing
  assign sif.raw = {~high_power_led_cathode, overtemp_cmp, 1'b0, overvoltage_cmp};
  ldfm_sync u_sync (
    .clk (clk),
    .rst (rst),
    .sif (sif.sync)
  );

  localparam ldfm_cnt_t WDOG_CYC = ldfm_cnt_t'(`LDFM_WDOG_CYC);
  localparam ldfm_cnt_t STEP_CYC = ldfm_cnt_t'(`LDFM_STEP_CYC);

  ldfm_flags_t flags_reg, flags_next;
  ldfm_cnt_t   fcnt_reg, fcnt_next;
  ldfm_cnt_t   scnt_reg, scnt_next;
  ldfm_state_t st_reg, st_next;
  logic        oe_n_reg, oe_n_next;
  logic        en_reg, en_next;
  logic        flash_on, two_pin, clr, scp_done_reg, scp_done_next;
  ldfm_cnt_t   flash_limit;

  assign two_pin  = interface_select;
  // both selects high is flash in two-pin mode; strobe level in serial mode
  assign flash_on = two_pin ? (mode_select_hi & mode_select_lo) : flash_trigger_in;
  // fixed limit in two-pin mode, programmable only in serial mode
  assign flash_limit = two_pin ? WDOG_CYC
                     : ldfm_cnt_t'(WDOG_CYC - ldfm_cnt_t'(flash_duration_code) * STEP_CYC);
  // clear sources per interface mode
  assign clr = two_pin ? (~mode_select_hi & ~mode_select_lo)
                       : (out_sel_wr && out_sel_data == `LDFM_CLR_CODE);

  // fault flags, timers and enable next-state
  always_comb begin
    flags_next    = flags_reg;
    fcnt_next     = fcnt_reg;
    scnt_next     = scnt_reg;
    scp_done_next = scp_done_reg;
    st_next       = st_reg;
    // flash watchdog counts only while flash is held
    if (flash_on && st_reg != LDFM_FAULT) fcnt_next = ldfm_cnt_t'(fcnt_reg + 1);
    else fcnt_next = '0;
    // short detection window starts each time torch is enabled
    if (!torch_enable) begin
      scnt_next     = '0;
      scp_done_next = 1'b0;
    end else if (!scp_done_reg) begin
      scnt_next = ldfm_cnt_t'(scnt_reg + 1);
      if (scnt_reg + 1 >= WDOG_CYC) scp_done_next = 1'b1;
    end
    // clear first, then sets so a coincident event wins
    if (clr) flags_next = '0;
    if (sif.clean[`LDFM_BIT_OV]) flags_next[`LDFM_BIT_OV] = 1'b1;
    if (sif.clean[`LDFM_BIT_OT]) flags_next[`LDFM_BIT_OT] = 1'b1;
    if (flash_on && (two_pin || !timed_flash_select) && st_reg != LDFM_FAULT
        && fcnt_reg >= flash_limit)
      flags_next[`LDFM_BIT_TMR] = 1'b1;
    if (torch_enable && !scp_done_reg && scnt_reg + 1 >= WDOG_CYC
        && sif.clean[`LDFM_BIT_SCP])
      flags_next[`LDFM_BIT_SCP] = 1'b1;
    // device stays disabled while any flag latched
    case (st_reg)
      LDFM_IDLE:  st_next = (|flags_next) ? LDFM_FAULT : LDFM_RUN;
      LDFM_RUN:   st_next = (|flags_next) ? LDFM_FAULT : LDFM_RUN;
      LDFM_FAULT: st_next = (|flags_next) ? LDFM_FAULT : LDFM_RUN;
      default:    st_next = LDFM_IDLE;
    endcase
    en_next  = (st_next == LDFM_RUN);
    oe_n_next = ~(|flags_next);
  end

  // registers return to zero on enable low, lockout or power-on, except oe_n_reg which returns to one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg    <= 4'h0;
      fcnt_reg     <= 32'h0;
      scnt_reg     <= 32'h0;
      scp_done_reg <= 1'b0;
      st_reg       <= LDFM_IDLE;
      oe_n_reg     <= 1'b1;
      en_reg       <= 1'b0;
    end else begin
      flags_reg    <= flags_next;
      fcnt_reg     <= fcnt_next;
      scnt_reg     <= scnt_next;
      scp_done_reg <= scp_done_next;
      st_reg       <= st_next;
      oe_n_reg     <= oe_n_next;
      en_reg       <= en_next;
    end
  end

  // open drain: pin value always low, enable low means pulling
  assign int_n_o       = 1'b0;
  assign int_n_oe_n    = oe_n_reg;
  assign fault_flags   = flags_reg;
  assign driver_enable = en_reg;

  property p_int_follows_flags;
    @(posedge clk) disable iff (rst) (|flags_reg) |-> !oe_n_reg;
  endproperty
  a_int_follows_flags: assert property (p_int_follows_flags)
    else $error("interrupt not asserted with latched flag");

  property p_ov_sets;
    @(posedge clk) disable iff (rst)
      sif.clean[`LDFM_BIT_OV] |=> flags_reg[`LDFM_BIT_OV] && int_n_oe_n == 1'b0;
  endproperty
  a_ov_sets: assert property (p_ov_sets)
    else $error("overvoltage not latched");

  property p_ot_sets;
    @(posedge clk) disable iff (rst) sif.clean[2] |=> flags_reg[2];
  endproperty
  a_ot_sets: assert property (p_ot_sets)
    else $error("overtemperature not latched");

  property p_sticky;
    @(posedge clk) disable iff (rst) (flags_reg[0] && !clr) |=> flags_reg[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

  sequence s_clear_quiet;
    clr && !sif.clean[0] && !sif.clean[2] && !flash_on && !torch_enable;
  endsequence
  property p_clear;
    @(posedge clk) disable iff (rst) s_clear_quiet |=> flags_reg == 4'h0 ##1 1;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not empty flags");

  property p_disabled_on_fault;
    @(posedge clk) disable iff (rst) (|flags_reg) |-> !en_reg;
  endproperty
  a_disabled_on_fault: assert property (p_disabled_on_fault)
    else $error("driver enabled with fault");

  property p_wdog_two_pin;
    @(posedge clk) disable iff (rst)
      (two_pin && flash_on && fcnt_reg == WDOG_CYC) |=> flags_reg[1];
  endproperty
  a_wdog_two_pin: assert property (p_wdog_two_pin)
    else $error("two-pin watchdog missed");

  property p_timed_no_fault;
    @(posedge clk) disable iff (rst)
      (!two_pin && timed_flash_select && !clr && !flags_reg[1]) |=> !$rose(flags_reg[1]);
  endproperty
  a_timed_no_fault: assert property (p_timed_no_fault)
    else $error("timeout flag in timed mode");

  // a synchronised overvoltage or overtemperature shuts the driver and pulls the line at the next edge
  sequence s_fault_seen;
    sif.clean[`LDFM_BIT_OV] || sif.clean[`LDFM_BIT_OT];
  endsequence
  property p_fault_pulls_line;
    @(posedge clk) disable iff (rst) s_fault_seen |=> !oe_n_reg && !en_reg;
  endproperty
  a_fault_pulls_line: assert property (p_fault_pulls_line)
    else $error("fault did not pull interrupt");

  // a nonzero output select write must leave a latched overvoltage flag alone
  property p_nonzero_write_keeps;
    @(posedge clk) disable iff (rst)
      (!two_pin && out_sel_wr && out_sel_data != `LDFM_CLR_CODE && flags_reg[`LDFM_BIT_OV])
      |=> flags_reg[`LDFM_BIT_OV];
  endproperty
  a_nonzero_write_keeps: assert property (p_nonzero_write_keeps)
    else $error("nonzero write cleared a flag");

  // watchdog is held at zero while the device sits in fault
  property p_wdog_idle_in_fault;
    @(posedge clk) disable iff (rst) (st_reg == LDFM_FAULT) |=> (fcnt_reg == '0);
  endproperty
  a_wdog_idle_in_fault: assert property (p_wdog_idle_in_fault)
    else $error("watchdog ran during fault");

  // both selects low empty the flags once every comparator is quiet
  property p_two_pin_clear;
    @(posedge clk) disable iff (rst)
      (two_pin && clr && !sif.clean[`LDFM_BIT_OV] && !sif.clean[`LDFM_BIT_OT]
       && !sif.clean[`LDFM_BIT_SCP]) |=> (flags_reg == 4'h0);
  endproperty
  a_two_pin_clear: assert property (p_two_pin_clear)
    else $error("two-pin clear left a flag");

  // line released exactly when nothing is latched
  property p_release_when_empty;
    @(posedge clk) disable iff (rst) (flags_reg == 4'h0) |-> oe_n_reg;
  endproperty
  a_release_when_empty: assert property (p_release_when_empty)
    else $error("interrupt held with no flag");
endmodule

// ==== inc/ldfm_cfg.svh ====
// Purpose: constants for the led driver fault monitor
// Assumes: 100 MHz clock
// Notes:   watchdog time in ms, step time in us, cycle counts derived from them
`ifndef LDFM_CFG_SVH
`define LDFM_CFG_SVH
`define LDFM_CLK_HZ        100000000
`define LDFM_WDOG_MS       820
`define LDFM_STEP_US       54600
`define LDFM_WDOG_CYC      ((`LDFM_WDOG_MS * (`LDFM_CLK_HZ / 1000)))
`define LDFM_STEP_CYC      ((`LDFM_STEP_US * (`LDFM_CLK_HZ / 1000000)))
`define LDFM_CLR_CODE      8'h00
`define LDFM_BIT_OV        0
`define LDFM_BIT_TMR       1
`define LDFM_BIT_OT        2
`define LDFM_BIT_SCP       3
`define LDFM_CNT_W         32
`endif

// ==== inc/ldfm_pkg.sv ====
// Purpose: shared types for the led driver fault monitor
// Assumes: none
// Notes:   flag vector order follows the fault bit positions
package ldfm_pkg;
  typedef logic [3:0] ldfm_flags_t;
  typedef logic [31:0] ldfm_cnt_t;
  typedef enum logic [1:0] {
    LDFM_IDLE  = 2'b00,
    LDFM_RUN   = 2'b01,
    LDFM_FAULT = 2'b11
  } ldfm_state_t;
endpackage

// ==== inc/ldfm_sync_if.sv ====
// Purpose: carrier between the top and the synchroniser
// Assumes: one clock
// Notes:   raw comparator levels in, clean levels out
interface ldfm_sync_if;
  logic [3:0] raw;
  logic [3:0] clean;
  modport top  (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// ==== logic/ldfm_sync.sv ====
// Purpose: two-flop synchroniser for the analog comparator levels
// Assumes: asynchronous active-high reset
// Notes:   first stage feeds only the second
module ldfm_sync (
  input wire logic clk,
  input wire logic rst,
  ldfm_sync_if.sync sif
);
  import ldfm_pkg::*;
  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] clean_reg;
  logic [3:0] clean_next;
  // next values: one stage shift
  always_comb begin
    meta_next  = sif.raw;
    clean_next = meta_reg;
  end
  // register both stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg  <= 4'h0;
      clean_reg <= 4'h0;
    end else begin
      meta_reg  <= meta_next;
      clean_reg <= clean_next;
    end
  end
  assign sif.clean = clean_reg;
endmodule

// ==== verif/ldfm_host_model.sv ====
// Purpose: baseband host on the serial side of the fault monitor
// Assumes: interrupt line already resolved with its pull-up
// Notes:   writes are one cycle wide, launched on the falling edge
module ldfm_host_model (
  input  wire logic       clk,
  input  wire logic       int_line,
  input  wire logic [3:0] flags_in,
  output logic            wr_o,
  output logic [7:0]      data_o,
  output logic [3:0]      seen_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic int_prev = 1'b1;
  initial begin
    wr_o = 1'b0;
    data_o = 8'hA5;
    seen_flags = 4'h0;
  end
  // read the flags once the line has fallen, as a polling host would
  always @(posedge clk) begin
    if (int_prev && !int_line) seen_flags <= flags_in;
    int_prev <= int_line;
  end
  // idle data is inverted so a stale zero never clears by luck
  task automatic write(input logic [7:0] val);
    @(negedge clk);
    wr_o = 1'b1;
    data_o = val;
    @(negedge clk);
    wr_o = 1'b0;
    data_o = ~val;
  endtask
endmodule

// ==== verif/ldfm_top_tb_top.sv ====
// Purpose: self-checking bench for the led driver fault monitor
// Assumes: inputs change on the falling clock edge
// Notes:   timeout and short checks need 82M cycles, too long to run here
module ldfm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ldfm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        interface_select = 1'b0;
  logic        mode_select_hi = 1'b0;
  logic        mode_select_lo = 1'b0;
  logic        flash_trigger_in = 1'b0;
  logic        timed_flash_select = 1'b0;
  logic        torch_enable = 1'b0;
  logic        overvoltage_cmp = 1'b0;
  logic        overtemp_cmp = 1'b0;
  logic        out_sel_wr;
  logic [7:0]  out_sel_data;
  logic        int_n_o;
  logic        int_n_oe_n;
  ldfm_flags_t fault_flags;
  logic [3:0]  seen_flags;
  logic        driver_enable;
  int          fail_count = 0;
  int          checks_done = 0;
  // pull-up resolves the open-drain line
  wire         int_line = int_n_oe_n ? 1'b1 : int_n_o;

  ldfm_top u_ldfm_top (.clk(clk), .rst(rst), .interface_select(interface_select),
    .mode_select_hi(mode_select_hi), .mode_select_lo(mode_select_lo),
    .flash_trigger_in(flash_trigger_in), .timed_flash_select(timed_flash_select),
    .flash_duration_code(4'h0), .torch_enable(torch_enable),
    .out_sel_wr(out_sel_wr), .out_sel_data(out_sel_data), .overvoltage_cmp(overvoltage_cmp),
    .overtemp_cmp(overtemp_cmp), .high_power_led_cathode(1'b1), .int_n_o(int_n_o),
    .int_n_oe_n(int_n_oe_n), .fault_flags(fault_flags), .driver_enable(driver_enable));
  ldfm_host_model u_ldfm_host_model (.clk(clk), .int_line(int_line),
    .flags_in(fault_flags), .wr_o(out_sel_wr), .data_o(out_sel_data),
    .seen_flags(seen_flags));

  // free-running 100 MHz clock
  initial forever #5 clk = ~clk;

  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait: the synchroniser needs a few edges before the flag shows
  task automatic wait_flags(input logic [3:0] exp);
    int n;
    n = 0;
    while (fault_flags !== exp && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("fault_flags", {4'h0, exp}, {4'h0, fault_flags});
  endtask
  task automatic ends_clear;
    chk("fault_flags", 8'h00, {4'h0, fault_flags});
    chk("int_n_oe_n", 8'h01, {7'h00, int_n_oe_n});
  endtask
  // serial overvoltage: latched, read back, cleared only by a zero write
  task automatic t_overvoltage;
    @(negedge clk) overvoltage_cmp = 1'b1;
    wait_flags(4'h1);
    chk("int_n_oe_n", 8'h00, {7'h00, int_n_oe_n});
    chk("int_line", 8'h00, {7'h00, int_line});
    chk("driver_enable", 8'h00, {7'h00, driver_enable});
    overvoltage_cmp = 1'b0;
    repeat (6) @(negedge clk);
    chk("host_flags", 8'h01, {4'h0, seen_flags});
    chk("sticky", 8'h01, {4'h0, fault_flags});
    u_ldfm_host_model.write(8'h01);
    repeat (2) @(negedge clk);
    chk("nonzero_write", 8'h01, {4'h0, fault_flags});
    u_ldfm_host_model.write(8'h00);
    repeat (2) @(negedge clk);
    ends_clear();
  endtask
  // two-pin overtemperature with torch on; both selects low clear it
  task automatic t_overtemp;
    @(negedge clk);
    interface_select = 1'b1;
    mode_select_hi = 1'b1;
    // torch is only turned on here and left on, never stepped between nonzero levels
    torch_enable = 1'b1;
    overtemp_cmp = 1'b1;
    wait_flags(4'h4);
    chk("int_n_oe_n", 8'h00, {7'h00, int_n_oe_n});
    overtemp_cmp = 1'b0;
    mode_select_hi = 1'b0;
    repeat (5) @(negedge clk);
    ends_clear();
  endtask
  // short strobes and flashes raise nothing; a lone low select does not clear
  task automatic t_held_modes;
    @(negedge clk);
    interface_select = 1'b0;
    flash_trigger_in = 1'b1;
    repeat (40) @(negedge clk);
    timed_flash_select = 1'b1;
    repeat (40) @(negedge clk);
    chk("strobe_flags", 8'h00, {4'h0, fault_flags});
    chk("strobe_enable", 8'h01, {7'h00, driver_enable});
    flash_trigger_in = 1'b0;
    timed_flash_select = 1'b0;
    interface_select = 1'b1;
    mode_select_hi = 1'b1;
    mode_select_lo = 1'b1;
    repeat (40) @(negedge clk);
    chk("flash_flags", 8'h00, {4'h0, fault_flags});
    mode_select_hi = 1'b0;
    overtemp_cmp = 1'b1;
    wait_flags(4'h4);
    overtemp_cmp = 1'b0;
    repeat (5) @(negedge clk);
    chk("held_flag", 8'h04, {4'h0, fault_flags});
    mode_select_lo = 1'b0;
    repeat (2) @(negedge clk);
    ends_clear();
  endtask
  // reset in mid-fault drops every flag and releases the line
  task automatic t_reset_mid;
    @(negedge clk) overvoltage_cmp = 1'b1;
    wait_flags(4'h1);
    rst = 1'b1;
    overvoltage_cmp = 1'b0;
    @(negedge clk) ends_clear();
    rst = 1'b0;
    @(negedge clk);
    chk("driver_enable", 8'h01, {7'h00, driver_enable});
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    @(negedge clk);
    ends_clear();
    t_overvoltage();
    t_overtemp();
    t_held_modes();
    t_reset_mid();
    end_of_test();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule
